//--- hdl/sci_ctrl.sv
// Serial port control, status and bit-rate logic behind an APB slave
`timescale 1ns/1ps
`default_nettype none
module sci_ctrl
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd_in,
	output logic             txd_out,
	output logic             txd_oe,
	output logic             sci_irq
);
	logic [7:0] ctrl_reg;
	logic [4:0] baud_hi_reg;
	logic [2:0] baud_rate_sel;
	logic [7:0] status;
	logic [7:0] arm_reg;
	logic [31:0] prdata_reg;
	logic [5:0] pre_cnt_reg;
	logic [5:0] pre_div;
	logic [6:0] rate_cnt_reg;
	logic [6:0] rate_mask;
	logic [3:0] tx_rt_reg;
	logic pre_tick, rt_tick, bit_tick;
	logic setup, access, wr, rd, hit;
	logic [13:0] idx;
	logic wr_baud, wr_ctrl, wr_data, rd_stat, rd_data;
	logic tx_buf_empty_flag, tc, rx_buf_full_flag, idle, ovr, nf, fe;
	logic tx_pre_pend, tx_brk_pend, te_q;
	sci_pkg::tx_state_t tx_state;
	logic [9:0] tx_shift_reg;
	logic [3:0] tx_cnt_reg;
	logic [7:0] tx_buf_reg;
	logic tx_idle_cond;
	logic rx_active;
	logic [3:0] rx_phase, rx_bitn;
	logic [7:0] rx_shift_reg, rx_data_reg;
	logic [2:0] votes;
	logic rx_noise, vote_bit, frame_done;
	logic [7:0] quiet_cnt;
	logic line_busy, idle_seen;
	logic irq_next;
	logic baud_counter_clear;
	logic [2:0] pre_sel;

	// APB decode; index is the byte address over four
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign idx = paddr[15:2];
	assign hit = paddr[1:0] == 2'h0 &&
		(idx == sci_pkg::BAUD_IDX[13:0] || idx == sci_pkg::CTRL_IDX[13:0]
		|| idx == sci_pkg::STAT_IDX[13:0] || idx == sci_pkg::DATA_IDX[13:0]);
	assign wr = access && pwrite && hit;
	assign rd = access && !pwrite && hit;
	assign wr_baud = wr && idx == sci_pkg::BAUD_IDX[13:0];
	assign wr_ctrl = wr && idx == sci_pkg::CTRL_IDX[13:0];
	assign wr_data = wr && idx == sci_pkg::DATA_IDX[13:0];
	assign rd_stat = rd && idx == sci_pkg::STAT_IDX[13:0];
	assign rd_data = rd && idx == sci_pkg::DATA_IDX[13:0];
	assign pready = 1'b1;
	assign pslverr = access && !hit;
	assign prdata = prdata_reg;

	// Status word as software sees it
	always_comb
	begin
		status = 8'h00;
		status[sci_pkg::STS_TX_BUF_EMPTY_FLAG] = tx_buf_empty_flag;
		status[sci_pkg::STS_TC] = tc;
		status[sci_pkg::STS_RX_BUF_FULL_FLAG] = rx_buf_full_flag;
		status[sci_pkg::STS_IDLE] = idle;
		status[sci_pkg::STS_OR] = ovr;
		status[sci_pkg::STS_NF] = nf;
		status[sci_pkg::STS_FE] = fe;
	end

	// Read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else if (setup && !pwrite)
		begin
			prdata_reg <= 32'h0000_0000;
			case (paddr[15:2])
				sci_pkg::BAUD_IDX[13:0]:
					prdata_reg[7:0] <= {baud_hi_reg, baud_rate_sel};
				sci_pkg::CTRL_IDX[13:0]:
					prdata_reg[7:0] <= ctrl_reg;
				sci_pkg::STAT_IDX[13:0]:
					prdata_reg[7:0] <= status;
				sci_pkg::DATA_IDX[13:0]:
					prdata_reg[7:0] <= rx_data_reg;
				default:
					prdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Control register; sleep also cleared by hardware on idle line
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= sci_pkg::CTRL_RST;
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= pwdata[7:0];
			if (idle_seen && ctrl_reg[sci_pkg::CTL_RWU])
				ctrl_reg[sci_pkg::CTL_RWU] <= 1'b0;
		end
	end

	// Upper bit-rate fields are reset; the rate select is not
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			baud_hi_reg <= sci_pkg::BAUD_HI_RST;
		else if (wr_baud)
			baud_hi_reg <= pwdata[7:3];
	end

	// Rate select survives reset
	always_ff @(posedge pclk)
	begin
		if (wr_baud)
			baud_rate_sel <= pwdata[2:0];
	end

	assign baud_counter_clear = baud_hi_reg[sci_pkg::BAUD_BAUD_COUNTER_CLEAR - 3];
	assign pre_sel = baud_hi_reg[sci_pkg::BAUD_PRE_LO - 1 -: 3];

	// Prescaler ratio; undecoded codes fall back to the fastest
	always_comb
	begin
		case (pre_sel)
			3'h0: pre_div = sci_pkg::PRE_DIV_0;
			3'h1: pre_div = sci_pkg::PRE_DIV_1;
			3'h2: pre_div = sci_pkg::PRE_DIV_2;
			3'h3: pre_div = sci_pkg::PRE_DIV_3;
			3'h4: pre_div = sci_pkg::PRE_DIV_4;
			default: pre_div = sci_pkg::PRE_DIV_0;
		endcase
	end

	assign pre_tick = !baud_counter_clear && pre_cnt_reg >= pre_div - 6'h01;
	assign rate_mask = 7'((8'h01 << baud_rate_sel) - 8'h01);
	assign rt_tick = pre_tick && (rate_cnt_reg & rate_mask) == rate_mask;
	assign bit_tick = rt_tick && tx_rt_reg == sci_pkg::RT_LAST;

	// Prescaler, binary divider and bit-clock divider; test bit holds clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_cnt_reg <= 6'h00;
			rate_cnt_reg <= 7'h00;
			tx_rt_reg <= 4'h0;
		end
		else if (baud_counter_clear)
		begin
			pre_cnt_reg <= 6'h00;
			rate_cnt_reg <= 7'h00;
			tx_rt_reg <= 4'h0;
		end
		else
		begin
			pre_cnt_reg <= pre_tick ? 6'h00 : pre_cnt_reg + 6'h01;
			if (pre_tick)
				rate_cnt_reg <= rate_cnt_reg + 7'h01;
			if (rt_tick)
				tx_rt_reg <= tx_rt_reg + 4'h1;
		end
	end

	// Status snapshot that arms the clear on the following data access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			arm_reg <= 8'h00;
		else if (rd_stat)
			arm_reg <= status;
		else if (wr_data)
			arm_reg[7:6] <= 2'h0;
		else if (rd_data)
			arm_reg[5:0] <= 6'h00;
	end

	// Transmitter pending work: preamble on enable, break on request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			te_q <= 1'b0;
			tx_pre_pend <= 1'b0;
			tx_brk_pend <= 1'b0;
		end
		else
		begin
			te_q <= ctrl_reg[sci_pkg::CTL_TE];
			if (ctrl_reg[sci_pkg::CTL_TE] && !te_q)
				tx_pre_pend <= 1'b1;
			else if (bit_tick && tx_state == sci_pkg::TX_IDLE)
				tx_pre_pend <= 1'b0;
			if (wr_ctrl && pwdata[sci_pkg::CTL_SBK])
				tx_brk_pend <= 1'b1;
			else if (bit_tick && tx_state == sci_pkg::TX_IDLE && !tx_pre_pend)
				tx_brk_pend <= 1'b0;
		end
	end

	// Frame shifter, one bit per bit-clock tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state <= sci_pkg::TX_IDLE;
			tx_shift_reg <= 10'h3FF;
			tx_cnt_reg <= 4'h0;
		end
		else if (bit_tick)
		begin
			case (tx_state)
				sci_pkg::TX_IDLE:
				begin
					tx_cnt_reg <= 4'h0;
					if (!ctrl_reg[sci_pkg::CTL_TE])
						tx_shift_reg <= 10'h3FF;
					else if (tx_pre_pend)
					begin
						tx_shift_reg <= 10'h3FF;
						tx_state <= sci_pkg::TX_SHIFT;
					end
					else if (tx_brk_pend || ctrl_reg[sci_pkg::CTL_SBK])
					begin
						tx_shift_reg <= 10'h000;
						tx_state <= sci_pkg::TX_SHIFT;
					end
					else if (!tx_buf_empty_flag)
					begin
						tx_shift_reg <= {1'b1, tx_buf_reg, 1'b0};
						tx_state <= sci_pkg::TX_SHIFT;
					end
				end
				sci_pkg::TX_SHIFT:
				begin
					tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
					tx_cnt_reg <= tx_cnt_reg + 4'h1;
					if (tx_cnt_reg == sci_pkg::CHAR_BITS - 4'h1)
						tx_state <= sci_pkg::TX_IDLE;
				end
				default:
					tx_state <= sci_pkg::TX_IDLE;
			endcase
		end
	end

	// Line drive; pin released once disabled and idle
	assign txd_out = tx_state == sci_pkg::TX_SHIFT ? tx_shift_reg[0] : 1'b1;
	assign txd_oe = ctrl_reg[sci_pkg::CTL_TE] || tx_state == sci_pkg::TX_SHIFT;

	// Transmit buffer register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_buf_reg <= 8'h00;
		else if (wr_data)
			tx_buf_reg <= pwdata[7:0];
	end

	assign tx_idle_cond = tx_state == sci_pkg::TX_IDLE && !tx_pre_pend
		&& !tx_brk_pend && !ctrl_reg[sci_pkg::CTL_SBK]
		&& (tx_buf_empty_flag || !ctrl_reg[sci_pkg::CTL_TE])
		&& !(wr_data && arm_reg[sci_pkg::STS_TX_BUF_EMPTY_FLAG]);

	// Transmit flags; a set in the clearing cycle wins for the empty flag, while an armed data write blocks the tc set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_buf_empty_flag <= 1'b1;
			tc <= 1'b1;
		end
		else
		begin
			if (bit_tick && tx_state == sci_pkg::TX_IDLE && !tx_buf_empty_flag
				&& ctrl_reg[sci_pkg::CTL_TE] && !tx_pre_pend
				&& !tx_brk_pend && !ctrl_reg[sci_pkg::CTL_SBK])
				tx_buf_empty_flag <= 1'b1;
			else if (!ctrl_reg[sci_pkg::CTL_TE] && tx_state == sci_pkg::TX_IDLE)
				tx_buf_empty_flag <= 1'b1;
			else if (wr_data && arm_reg[sci_pkg::STS_TX_BUF_EMPTY_FLAG])
				tx_buf_empty_flag <= 1'b0;
			if (tx_idle_cond)
				tc <= 1'b1;
			else if (wr_data && arm_reg[sci_pkg::STS_TC])
				tc <= 1'b0;
		end
	end

	// Majority vote over the three centre samples
	assign vote_bit = (votes[0] & votes[1]) | (votes[0] & rxd_in)
		| (votes[1] & rxd_in);
	assign rx_noise = !(votes[0] == votes[1] && votes[1] == rxd_in);
	assign frame_done = rt_tick && rx_active && rx_phase == sci_pkg::VOTE_C
		&& rx_bitn == sci_pkg::CHAR_BITS - 4'h1;

	// Receiver: start search, sampling and shifting
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_active <= 1'b0;
			rx_phase <= 4'h0;
			rx_bitn <= 4'h0;
			votes <= 3'h0;
			rx_shift_reg <= 8'h00;
		end
		else if (!ctrl_reg[sci_pkg::CTL_RE])
			rx_active <= 1'b0;
		else if (rt_tick)
		begin
			if (!rx_active)
			begin
				rx_active <= !rxd_in;
				rx_phase <= 4'h1;
				rx_bitn <= 4'h0;
				votes[2] <= 1'b0;
			end
			else
			begin
				rx_phase <= rx_phase + 4'h1;
				if (rx_phase == sci_pkg::VOTE_A)
					votes[0] <= rxd_in;
				if (rx_phase == sci_pkg::VOTE_B)
					votes[1] <= rxd_in;
				if (rx_phase == sci_pkg::VOTE_C)
				begin
					rx_bitn <= rx_bitn + 4'h1;
					votes[2] <= votes[2] | rx_noise;
					if (rx_bitn == 4'h0 && vote_bit)
						rx_active <= 1'b0;
					if (rx_bitn != 4'h0 && rx_bitn != 4'h9)
						rx_shift_reg <= {vote_bit, rx_shift_reg[7:1]};
					if (frame_done)
						rx_active <= 1'b0;
				end
			end
		end
	end

	// Receive flags; set beats a clearing data read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_buf_full_flag <= 1'b0;
			ovr <= 1'b0;
			nf <= 1'b0;
			fe <= 1'b0;
			rx_data_reg <= 8'h00;
		end
		else if (frame_done && !ctrl_reg[sci_pkg::CTL_RWU])
		begin
			if (rx_buf_full_flag || fe)
				ovr <= 1'b1;
			else
			begin
				rx_buf_full_flag <= 1'b1;
				rx_data_reg <= rx_shift_reg;
				nf <= votes[2] | rx_noise;
				fe <= !vote_bit;
			end
		end
		else if (rd_data)
		begin
			if (arm_reg[sci_pkg::STS_RX_BUF_FULL_FLAG])
				rx_buf_full_flag <= 1'b0;
			if (arm_reg[sci_pkg::STS_OR])
				ovr <= 1'b0;
			if (arm_reg[sci_pkg::STS_NF])
				nf <= 1'b0;
			if (arm_reg[sci_pkg::STS_FE])
				fe <= 1'b0;
		end
	end

	assign idle_seen = line_busy && quiet_cnt == sci_pkg::IDLE_RT;

	// Idle detection: a full character of ones after activity
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			quiet_cnt <= 8'h00;
			line_busy <= 1'b0;
			idle <= 1'b0;
		end
		else
		begin
			if (!ctrl_reg[sci_pkg::CTL_RE] || rx_active || !rxd_in)
				quiet_cnt <= 8'h00;
			else if (rt_tick && quiet_cnt != sci_pkg::IDLE_RT)
				quiet_cnt <= quiet_cnt + 8'h01;
			if (rx_active)
				line_busy <= 1'b1;
			else if (idle_seen)
				line_busy <= 1'b0;
			if (idle_seen && !ctrl_reg[sci_pkg::CTL_RWU])
				idle <= 1'b1;
			else if (rd_data && arm_reg[sci_pkg::STS_IDLE])
				idle <= 1'b0;
		end
	end

	// Interrupt sources gated by their enables, receiver ones by sleep
	assign irq_next = (ctrl_reg[sci_pkg::CTL_TIE] && tx_buf_empty_flag)
		|| (ctrl_reg[sci_pkg::CTL_TX_DONE_IRQ_EN] && tc)
		|| (ctrl_reg[sci_pkg::CTL_RIE] && !ctrl_reg[sci_pkg::CTL_RWU]
			&& (rx_buf_full_flag || ovr))
		|| (ctrl_reg[sci_pkg::CTL_LINE_QUIET_IRQ_EN] && !ctrl_reg[sci_pkg::CTL_RWU]
			&& idle);

	// Registered interrupt request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sci_irq <= 1'b0;
		else
			sci_irq <= irq_next;
	end

	// Checks
	tx_empty_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg[sci_pkg::CTL_TIE] && tx_buf_empty_flag |=> sci_irq)
		else $error("tx empty irq missing");
	tx_done_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg[sci_pkg::CTL_TX_DONE_IRQ_EN] && tc |=> sci_irq)
		else $error("tx done irq missing");
	rx_full_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg[sci_pkg::CTL_RIE] && !ctrl_reg[sci_pkg::CTL_RWU]
		&& (rx_buf_full_flag || ovr) |=> sci_irq)
		else $error("rx irq missing");
	idle_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg[sci_pkg::CTL_LINE_QUIET_IRQ_EN] && !ctrl_reg[sci_pkg::CTL_RWU]
		&& idle |=> sci_irq)
		else $error("idle irq missing");
	preamble_queue_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ctrl_reg[sci_pkg::CTL_TE]) |=> tx_pre_pend)
		else $error("preamble not queued");
	rx_disable_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_reg[sci_pkg::CTL_RE] |=> !rx_active)
		else $error("receiver runs while disabled");
	sleep_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg[sci_pkg::CTL_RWU] && !ctrl_reg[sci_pkg::CTL_TIE]
		&& !ctrl_reg[sci_pkg::CTL_TX_DONE_IRQ_EN] |=> !sci_irq)
		else $error("irq while asleep");
	break_queue_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl && pwdata[sci_pkg::CTL_SBK] |=> tx_brk_pend)
		else $error("break not queued");
	rx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_data && arm_reg[sci_pkg::STS_RX_BUF_FULL_FLAG] && !frame_done |=> !rx_buf_full_flag)
		else $error("rx_buf_full_flag not cleared");
	prescale_13_a: assert property (@(posedge pclk) disable iff (!presetn)
		pre_tick && pre_sel == 3'h3 && !wr_baud |=> !pre_tick [*8])
		else $error("prescaler too fast");
	stat_bit0_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && paddr[15:2] == sci_pkg::STAT_IDX[13:0]
		|=> prdata[0] == 1'b0)
		else $error("status bit 0 set");
endmodule // sci_ctrl
`default_nettype wire

//--- hdl/sci_pkg.sv
// Register map, field layout and timing constants of the serial port
package sci_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] BAUD_IDX = 16'h102B;
	localparam logic [15:0] CTRL_IDX = 16'h102C;
	localparam logic [15:0] STAT_IDX = 16'h102D;
	localparam logic [15:0] DATA_IDX = 16'h102E;
	// Control register fields
	localparam int CTL_TIE  = 7;
	localparam int CTL_TX_DONE_IRQ_EN = 6;
	localparam int CTL_RIE  = 5;
	localparam int CTL_LINE_QUIET_IRQ_EN = 4;
	localparam int CTL_TE   = 3;
	localparam int CTL_RE   = 2;
	localparam int CTL_RWU  = 1;
	localparam int CTL_SBK  = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Status register fields; bit 0 is unimplemented
	localparam int STS_TX_BUF_EMPTY_FLAG = 7;
	localparam int STS_TC   = 6;
	localparam int STS_RX_BUF_FULL_FLAG = 5;
	localparam int STS_IDLE = 4;
	localparam int STS_OR   = 3;
	localparam int STS_NF   = 2;
	localparam int STS_FE   = 1;
	// Bit-rate register fields
	localparam int BAUD_BAUD_COUNTER_CLEAR    = 7;
	localparam int BAUD_PRE_LO  = 4;
	localparam int BAUD_CHK     = 3;
	localparam int BAUD_RATE_LO = 0;
	localparam logic [4:0] BAUD_HI_RST = 5'h00;
	// Prescaler divide ratios
	localparam logic [5:0] PRE_DIV_0 = 6'h01;
	localparam logic [5:0] PRE_DIV_1 = 6'h03;
	localparam logic [5:0] PRE_DIV_2 = 6'h04;
	localparam logic [5:0] PRE_DIV_3 = 6'h0D;
	localparam logic [5:0] PRE_DIV_4 = 6'h27;
	// Sampling clock ticks per bit, bits per character
	localparam logic [3:0] RT_LAST = 4'hF;
	localparam logic [3:0] CHAR_BITS = 4'hA;
	localparam logic [7:0] IDLE_RT = 8'hA0;
	// Sampling phases of the majority vote
	localparam logic [3:0] VOTE_A = 4'h7;
	localparam logic [3:0] VOTE_B = 4'h8;
	localparam logic [3:0] VOTE_C = 4'h9;
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
endpackage

//--- tb/serial_station.sv
// Remote serial station model on the line side of the serial port
`timescale 1ns/1ps
`default_nettype none
module serial_station
(
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	int bit_len = 16;

	// Line idles high between frames
	initial rxd = 1'b1;

	// Send start, eight bits LSB first, stop; bit g gets one flipped vote
	task automatic send(input logic [7:0] d, input logic stp, input int g);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++)
			for (int c = 0; c < bit_len; c++)
			begin
				@(posedge pclk);
				rxd <= (i == g && c == 8) ? ~f[i] : f[i];
			end
		@(posedge pclk);
		rxd <= 1'b1;
	endtask

	// Catch one frame: cycles waited, start bit width and data byte
	task automatic listen(output int t, output int w, output logic [7:0] d);
		t = 0;
		w = 0;
		d = 8'h00;
		while (txd !== 1'b0 && t < 30000)
		begin
			@(negedge pclk);
			t++;
		end
		while (txd === 1'b0 && w < 5000)
		begin
			@(negedge pclk);
			w++;
		end
		repeat (bit_len / 2) @(negedge pclk);
		for (int i = 0; i < 8; i++)
		begin
			d[i] = txd;
			repeat (bit_len) @(negedge pclk);
		end
	endtask
endmodule // serial_station
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the serial port control and status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [15:0] A_BAUD = sci_pkg::BAUD_IDX << 2;
	localparam logic [15:0] A_CTRL = sci_pkg::CTRL_IDX << 2;
	localparam logic [15:0] A_STAT = sci_pkg::STAT_IDX << 2;
	localparam logic [15:0] A_DATA = sci_pkg::DATA_IDX << 2;
	logic        pclk;
	logic        presetn;
	logic [15:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        txd_oe;
	logic        irq;
	int          fail_count;
	int          checked;
	logic [7:0]  bv [5] = '{8'h00, 8'h10, 8'h21, 8'h30, 8'h40};
	int          per [5] = '{16, 48, 128, 208, 624};
	logic [7:0]  iv [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};

	// Bus clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	sci_ctrl i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd),
		.txd_out(txd), .txd_oe(txd_oe), .sci_irq(irq));
	serial_station i_st (.pclk(pclk), .txd(txd), .rxd(rxd));

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic chk(input logic [15:0] a, input logic [7:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 8'h00, r, e);
		cmp(r, {24'h000000, x});
	endtask

	task automatic irq_is(input logic x);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		cmp({31'h0, irq}, {31'h0, x});
	endtask

	task automatic conclude;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog against a hung run
	initial
	begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		$display("ERROR t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		conclude();
	end

	// Test sequence
	initial
	begin
		int          t;
		int          w;
		logic [7:0]  d;
		logic [31:0] r;
		logic        e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		fail_count = 0;
		checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wr(A_BAUD, 8'h4B);
		chk(A_BAUD, 8'h4B);
		chk(A_CTRL, 8'h00);
		chk(A_STAT, 8'hC0);
		apb(1'b0, 16'h40BC, 8'h00, r, e);
		cmp(r, 32'h00000000);
		cmp({31'h0, e}, 32'h00000001);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk(A_BAUD, 8'h03);
		$display("test registers done");
		for (int k = 0; k < 5; k++)
		begin
			wr(A_BAUD, bv[k]);
			i_st.bit_len = per[k];
			wr(A_CTRL, 8'h08);
			chk(A_STAT, 8'hC0);
			wr(A_DATA, 8'hA5);
			i_st.listen(t, w, d);
			cmp(w, per[k]);
			cmp({24'h0, d}, 32'h000000A5);
			cmp({31'h0, t >= 9 * per[k]}, 32'h1);
			repeat (2 * per[k]) @(posedge pclk);
			chk(A_STAT, 8'hC0);
			wr(A_CTRL, 8'h00);
		end
		$display("test rates done");
		i_st.bit_len = 16;
		wr(A_BAUD, 8'h00);
		for (int k = 0; k < 5; k++)
		begin
			wr(A_CTRL, iv[k]);
			irq_is(k < 2);
		end
		$display("test transmit interrupts done");
		wr(A_CTRL, 8'h24);
		i_st.send(8'h3C, 1'b1, 99);
		irq_is(1'b1);
		chk(A_STAT, 8'hE0);
		chk(A_DATA, 8'h3C);
		chk(A_STAT, 8'hC0);
		irq_is(1'b0);
		i_st.send(8'h11, 1'b1, 99);
		i_st.send(8'h22, 1'b1, 99);
		chk(A_STAT, 8'hE8);
		chk(A_DATA, 8'h11);
		i_st.send(8'h5A, 1'b1, 3);
		chk(A_STAT, 8'hE4);
		chk(A_DATA, 8'h5A);
		i_st.send(8'h0F, 1'b0, 99);
		chk(A_STAT, 8'hE2);
		chk(A_DATA, 8'h0F);
		$display("test receive flags done");
		wr(A_CTRL, 8'h14);
		repeat (200) @(posedge pclk);
		irq_is(1'b1);
		chk(A_STAT, 8'hD0);
		apb(1'b0, A_DATA, 8'h00, r, e);
		repeat (200) @(posedge pclk);
		chk(A_STAT, 8'hC0);
		wr(A_CTRL, 8'h26);
		i_st.send(8'h77, 1'b1, 99);
		irq_is(1'b0);
		chk(A_STAT, 8'hC0);
		repeat (200) @(posedge pclk);
		chk(A_CTRL, 8'h24);
		wr(A_CTRL, 8'h00);
		cmp({31'h0, txd_oe}, 32'h0);
		i_st.send(8'h66, 1'b1, 99);
		chk(A_STAT, 8'hC0);
		$display("test idle and sleep done");
		wr(A_CTRL, 8'h09);
		wr(A_CTRL, 8'h08);
		i_st.listen(t, w, d);
		cmp({31'h0, w >= 160}, 32'h1);
		wr(A_CTRL, 8'h00);
		repeat (400) @(posedge pclk);
		wr(A_CTRL, 8'h09);
		repeat (600) @(posedge pclk);
		@(negedge pclk);
		cmp({31'h0, txd}, 32'h0);
		wr(A_CTRL, 8'h08);
		repeat (400) @(posedge pclk);
		@(negedge pclk);
		cmp({31'h0, txd}, 32'h1);
		cmp({31'h0, txd_oe}, 32'h1);
		$display("test break done");
		conclude();
	end
endmodule // testbench
`default_nettype wire
